//--- hdl/pot_pkg.sv
`default_nettype none

package pot_pkg;

    // Array geometry
    localparam int CHANNELS = 4;
    localparam int STORES = 4;
    localparam int WIPER_W = 8;
    localparam int STORE_ADDR_W = 4;

    // Instruction opcodes, upper nibble of the instruction byte
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_STORE = 4'hB;
    localparam logic [3:0] OP_WR_STORE = 4'hC;
    localparam logic [3:0] OP_STORE_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_WIPER_TO_STORE = 4'hE;
    localparam logic [3:0] OP_GLOBAL_TO_WIPER = 4'h1;
    localparam logic [3:0] OP_GLOBAL_TO_STORE = 4'h8;
    localparam logic [3:0] OP_STEP = 4'h2;

    // Instruction byte field positions
    localparam int OP_MSB = 7;
    localparam int OP_LSB = 4;
    localparam int STORE_MSB = 3;
    localparam int STORE_LSB = 2;
    localparam int CH_MSB = 1;
    localparam int CH_LSB = 0;

    // Device type nibble of the address byte (value is arbitrary)
    localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'h6;

    // Bit counter marks within one byte plus acknowledge
    localparam logic [3:0] BYTE_DONE = 4'h8;
    localparam logic [3:0] ACK_DONE = 4'h9;

    // Reset and power-up values
    localparam logic [7:0] WIPER_RESET = 8'h00;
    localparam logic [7:0] WIPER_MAX = 8'hFF;
    localparam logic [1:0] POWERUP_STORE = 2'h0;

    // Nonvolatile write time, longest figure, rounded down to cycles
    localparam int CLK_MHZ = 100;
    localparam int NV_WRITE_MS = 10;
    localparam int NV_WRITE_COUNT = NV_WRITE_MS * 1000 * CLK_MHZ;

    // Serial port states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_INSTR, ST_DATA_IN, ST_DATA_OUT, ST_STEP, ST_WAIT_STOP, ST_IGNORE
    } port_state_t;

endpackage

`default_nettype wire

//--- hdl/quad_pot_wiper_command_port.sv
`default_nettype none

// Notes on behaviour
// - Sixteen 8-bit setting stores, four per channel.
// - Power-up copies store 0 into each wiper.
// - One volatile 8-bit wiper register per channel.
// - Wiper loads from bus or stores, saves back.
// - Device acks master bytes; master acks reads.
// - Filler instruction bits are ignored.
// - Clock high with data high steps up.
// - Clock high with data low steps down.
// - Opcode 1001 reads wiper value MSB first.
// - Opcode 1010 then data byte writes wiper.
// - Opcode 1011 reads selected setting store.
// - Opcode 1100 writes store after stop.
// - Opcode 1101 copies store into wiper.
// - Opcode 1110 saves wiper into store.
// - Opcode 0010 starts stepping until stop.
// - Opcode 0001 loads all wipers from stores.
// - Opcode 1000 saves all wipers to stores.
// - Store writes finish within 10 ms.
// - Up step toward high end, down toward low.
module quad_pot_wiper_command_port
    import pot_pkg::*;
#(
    parameter logic [3:0] DEVICE_TYPE = DEVICE_TYPE_DEFAULT,
    parameter int unsigned NV_WRITE_CYCLES = NV_WRITE_COUNT
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Two-wire serial bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Strapped device select pins
    input wire logic [3:0] dev_sel_i,
    // Wiper positions and write status
    output logic [CHANNELS-1:0][WIPER_W-1:0] wiper_o,
    output logic busy_o
);

    localparam int NVW = $clog2(NV_WRITE_CYCLES + 1);

    // Pin synchronisers and edge history
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    logic [3:0] sel_m, sel_s;

    // Serial port state
    port_state_t state;
    port_state_t after_ack;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] out_shift;
    logic ack_drive;
    logic out_drive;
    logic step_sda;
    logic step_inc;
    logic step_dec;

    // Latched command
    logic [3:0] cmd_op;
    logic [1:0] cmd_store;
    logic [1:0] cmd_ch;
    logic [7:0] cmd_data;
    logic pend;
    logic exec_go;

    // Execution sequencer and write timer
    logic seq_active;
    logic seq_save;
    logic [2:0] seq_cnt;
    logic [1:0] seq_store;
    logic [NVW-1:0] nv_cnt;
    logic busy;

    // Wipers
    logic [WIPER_W-1:0] wiper [CHANNELS];

    // Bus conditions seen on the synchronised pins
    logic scl_rise, scl_fall, start_det, stop_det;
    logic [7:0] read_value;
    logic op_valid;
    port_state_t op_next;
    logic store_write;

    setting_store_if store ();

    setting_store_mem #(
        .DEPTH(CHANNELS * STORES),
        .WIDTH(WIPER_W)
    ) u_store (
        .ref_clk_i(ref_clk_i),
        .port(store.mem)
    );

    // Two-stage synchronisers for the bus and select pins
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sel_m <= 4'h0;
            sel_s <= 4'h0;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sel_m <= dev_sel_i;
            sel_s <= sel_m;
        end
    end

    // One-cycle history for edge detection
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // Clock edges, start and stop conditions
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

    // Opcode decode: validity and state after the acknowledge
    always_comb begin
        op_valid = 1'b1;
        op_next = ST_WAIT_STOP;
        unique case (shift_in[OP_MSB:OP_LSB])
            OP_RD_WIPER, OP_RD_STORE: op_next = ST_DATA_OUT;
            OP_WR_WIPER, OP_WR_STORE: op_next = ST_DATA_IN;
            OP_STEP: op_next = ST_STEP;
            OP_STORE_TO_WIPER, OP_WIPER_TO_STORE: op_next = ST_WAIT_STOP;
            OP_GLOBAL_TO_WIPER, OP_GLOBAL_TO_STORE: op_next = ST_WAIT_STOP;
            default: op_valid = 1'b0;
        endcase
    end

    // Value returned in a read, wiper or addressed store
    assign read_value = (cmd_op == OP_RD_WIPER) ? wiper[cmd_ch] : store.rdata;

    // Serial port: framing, acknowledge and byte handling
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state <= ST_IDLE;
            after_ack <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
            out_shift <= 8'h00;
            ack_drive <= 1'b0;
            out_drive <= 1'b0;
            step_sda <= 1'b0;
            step_inc <= 1'b0;
            step_dec <= 1'b0;
            cmd_op <= 4'h0;
            cmd_store <= 2'h0;
            cmd_ch <= 2'h0;
            cmd_data <= 8'h00;
            pend <= 1'b0;
            exec_go <= 1'b0;
        end else begin
            step_inc <= 1'b0;
            step_dec <= 1'b0;
            exec_go <= 1'b0;
            if (start_det) begin
                // New frame, any half-sent command is dropped
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                pend <= 1'b0;
                ack_drive <= 1'b0;
                out_drive <= 1'b0;
            end else if (stop_det) begin
                // Stop releases the bus and launches a pending action
                exec_go <= pend;
                pend <= 1'b0;
                state <= ST_IDLE;
                ack_drive <= 1'b0;
                out_drive <= 1'b0;
            end else if (state != ST_IDLE) begin
                if (scl_rise) begin
                    if (bit_cnt < BYTE_DONE) begin
                        shift_in <= {shift_in[6:0], sda_s};
                    end
                    step_sda <= sda_s;
                    bit_cnt <= bit_cnt + 4'h1;
                end else if (scl_fall) begin
                    if (state == ST_STEP) begin
                        // Step counted at end of the high phase; a stop never ends one
                        step_inc <= step_sda;
                        step_dec <= ~step_sda;
                    end else if (bit_cnt == BYTE_DONE) begin
                        unique case (state)
                            ST_ADDR: begin
                                if (shift_in == {DEVICE_TYPE, sel_s} && !busy) begin
                                    ack_drive <= 1'b1;
                                    after_ack <= ST_INSTR;
                                end else begin
                                    state <= ST_IGNORE;
                                end
                            end
                            ST_INSTR: begin
                                // Filler bits latched but never looked at
                                cmd_op <= shift_in[OP_MSB:OP_LSB];
                                cmd_store <= shift_in[STORE_MSB:STORE_LSB];
                                cmd_ch <= shift_in[CH_MSB:CH_LSB];
                                if (op_valid) begin
                                    ack_drive <= 1'b1;
                                    after_ack <= op_next;
                                    pend <= (op_next == ST_WAIT_STOP);
                                end else begin
                                    state <= ST_IGNORE;
                                end
                            end
                            ST_DATA_IN: begin
                                cmd_data <= shift_in;
                                ack_drive <= 1'b1;
                                after_ack <= ST_WAIT_STOP;
                                pend <= 1'b1;
                            end
                            ST_DATA_OUT: begin
                                // Release the line for the master's acknowledge
                                out_drive <= 1'b0;
                                after_ack <= ST_WAIT_STOP;
                            end
                            ST_IDLE, ST_STEP, ST_WAIT_STOP, ST_IGNORE: begin
                                state <= ST_IGNORE;
                            end
                        endcase
                    end else if (bit_cnt == ACK_DONE) begin
                        ack_drive <= 1'b0;
                        bit_cnt <= 4'h0;
                        // A refused frame stays refused until start or stop
                        state <= (state == ST_IGNORE) ? ST_IGNORE : after_ack;
                        if (after_ack == ST_DATA_OUT && state != ST_DATA_OUT && state != ST_IGNORE) begin
                            out_shift <= read_value;
                            out_drive <= ~read_value[7];
                        end
                    end else if (state == ST_DATA_OUT) begin
                        // Next data bit, MSB first
                        out_shift <= {out_shift[6:0], 1'b0};
                        out_drive <= ~out_shift[6];
                    end
                end
            end
        end
    end

    // Open-drain data pin: only ever pulled low
    assign sda_o = 1'b0;
    assign sda_oe_o = ack_drive | out_drive;

    // Single store writes launched by a stop
    assign store_write = exec_go && (cmd_op == OP_WR_STORE || cmd_op == OP_WIPER_TO_STORE);

    // Global and power-up sequencer, one channel per cycle
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            seq_active <= 1'b1;
            seq_save <= 1'b0;
            seq_cnt <= 3'h0;
            seq_store <= POWERUP_STORE;
        end else if (seq_active) begin
            if (seq_cnt == (seq_save ? 3'h3 : 3'h4)) begin
                seq_active <= 1'b0;
                seq_cnt <= 3'h0;
            end else begin
                seq_cnt <= seq_cnt + 3'h1;
            end
        end else if (exec_go && cmd_op == OP_GLOBAL_TO_WIPER) begin
            seq_active <= 1'b1;
            seq_save <= 1'b0;
            seq_store <= cmd_store;
        end else if (exec_go && cmd_op == OP_GLOBAL_TO_STORE) begin
            seq_active <= 1'b1;
            seq_save <= 1'b1;
            seq_store <= cmd_store;
        end
    end

    // Nonvolatile write timer, blocks new frames while running
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            nv_cnt <= '0;
        end else if (store_write || (exec_go && cmd_op == OP_GLOBAL_TO_STORE)) begin
            nv_cnt <= NVW'(NV_WRITE_CYCLES);
        end else if (nv_cnt != '0) begin
            nv_cnt <= nv_cnt - NVW'(1);
        end
    end

    assign busy = (nv_cnt != '0) | seq_active;
    assign busy_o = busy;

    // Store port addressing, index is channel then store
    always_comb begin
        store.we = store_write | (seq_active & seq_save);
        if (seq_active) begin
            store.waddr = {seq_cnt[1:0], seq_store};
            store.wdata = wiper[seq_cnt[1:0]];
            store.raddr = {seq_cnt[1:0], seq_store};
        end else begin
            store.waddr = {cmd_ch, cmd_store};
            store.wdata = (cmd_op == OP_WR_STORE) ? cmd_data : wiper[cmd_ch];
            store.raddr = {cmd_ch, cmd_store};
        end
    end

    // Per-channel wiper registers
    generate
        for (genvar c = 0; c < CHANNELS; c++) begin : g_wiper
            always_ff @(posedge ref_clk_i) begin
                if (!resetn_i) begin
                    wiper[c] <= WIPER_RESET;
                end else if (seq_active && !seq_save && seq_cnt == 3'(c + 1)) begin
                    wiper[c] <= store.rdata;
                end else if (exec_go && cmd_op == OP_WR_WIPER && cmd_ch == 2'(c)) begin
                    wiper[c] <= cmd_data;
                end else if (exec_go && cmd_op == OP_STORE_TO_WIPER && cmd_ch == 2'(c)) begin
                    wiper[c] <= store.rdata;
                end else if (state == ST_STEP && cmd_ch == 2'(c)) begin
                    if (step_inc && wiper[c] != WIPER_MAX) begin
                        wiper[c] <= wiper[c] + 8'h01;
                    end else if (step_dec && wiper[c] != WIPER_RESET) begin
                        wiper[c] <= wiper[c] - 8'h01;
                    end
                end
            end
            assign wiper_o[c] = wiper[c];
        end
    endgenerate

endmodule // quad_pot_wiper_command_port

`default_nettype wire

//--- hdl/setting_store_if.sv
`default_nettype none

// Port of the setting store array: one write and one read per cycle
interface setting_store_if;
    logic we;
    logic [3:0] waddr;
    logic [7:0] wdata;
    logic [3:0] raddr;
    logic [7:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

//--- hdl/setting_store_mem.sv
`default_nettype none

module setting_store_mem #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 8
) (
    // Clock
    input wire logic ref_clk_i,
    // Store port
    setting_store_if.mem port
);

    logic [WIDTH-1:0] cells [DEPTH];

    // Nonvolatile cells hold across reset; blank part reads zero
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            cells[i] = '0;
        end
    end

    // Write port and registered read
    always_ff @(posedge ref_clk_i) begin
        if (port.we) begin
            cells[port.waddr] <= port.wdata;
        end
        port.rdata <= cells[port.raddr];
    end

endmodule // setting_store_mem

`default_nettype wire

//--- tb/bus_master_model.sv
`default_nettype none

module bus_master_model (
    // Clock and wire level
    input wire logic clk_i,
    input wire logic sda_i,
    // Driven lines
    output logic scl_o,
    output logic sda_oe_o,
    // Received bit or byte
    output logic res_o,
    output logic [7:0] res_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
        res_o = 1'b0;
        res_data_o = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Hand a result to the watcher
    task automatic report(input logic [7:0] d);
        res_data_o = d;
        res_o = 1'b1;
        tick(1);
        res_o = 1'b0;
    endtask
    // Level held through the high phase
    task automatic bit_out(input logic b);
        sda_oe_o = !b;
        tick(2);
        scl_o = 1'b1;
        tick(4);
        scl_o = 1'b0;
        tick(2);
    endtask
    // Released line, sampled mid high phase
    task automatic bit_in(output logic b);
        sda_oe_o = 1'b0;
        tick(2);
        scl_o = 1'b1;
        tick(2);
        b = sda_i;
        tick(2);
        scl_o = 1'b0;
        tick(2);
    endtask
    task automatic start();
        sda_oe_o = 1'b1;
        tick(4);
        scl_o = 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_oe_o = 1'b1;
        tick(2);
        scl_o = 1'b1;
        tick(4);
        sda_oe_o = 1'b0;
        tick(10);
    endtask
    // Byte out, MSB first, then device ack
    task automatic send_byte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(a);
        report({7'h00, !a});
    endtask
    // Byte in, then master ack
    task automatic read_byte();
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(1'b0);
        report(d);
    endtask
endmodule // bus_master_model

`default_nettype wire

//--- tb/pot_port_sva.sv
`default_nettype none

module pot_port_sva
    import pot_pkg::*;
#(
    parameter logic [3:0] DEVICE_TYPE = DEVICE_TYPE_DEFAULT,
    parameter int unsigned NV_WRITE_CYCLES = NV_WRITE_COUNT
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Bus pins and straps
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [3:0] dev_sel_i,
    // Wipers and status
    input wire logic [CHANNELS-1:0][WIPER_W-1:0] wiper_o,
    input wire logic busy_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    int unsigned busy_cnt;
    int unsigned idle_cnt;
    // Length of the current busy spell
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || !busy_o) busy_cnt <= 0;
        else busy_cnt <= busy_cnt + 1;
    end
    // Cycles of quiet bus while not busy
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || !(scl_i && sda_i) || busy_o) idle_cnt <= 0;
        else if (idle_cnt < 100) idle_cnt <= idle_cnt + 1;
    end
    sequence s_release;
        $rose(resetn_i);
    endsequence
    sequence s_powerup_end;
        busy_o ##[1:10] !busy_o;
    endsequence
    a_drive_low_only: assert property ($changed(sda_oe_o) |-> !scl_i && sda_o == 1'b0)
        else $error("sda changed outside scl low");
    a_oe_steady_high: assert property (scl_i [*3] |-> $stable(sda_oe_o))
        else $error("sda moved while scl high");
    a_reset_state: assert property (s_release |-> wiper_o == '0 && busy_o && !sda_oe_o)
        else $error("bad state after reset");
    a_powerup_done: assert property (s_release |-> s_powerup_end)
        else $error("power-up load did not finish");
    a_busy_quiet: assert property (busy_o |-> !sda_oe_o)
        else $error("acknowledge while busy");
    a_busy_bounded: assert property (busy_cnt <= NV_WRITE_CYCLES + 8)
        else $error("store write too long");
    a_busy_at_stop: assert property ($rose(busy_o) |-> scl_i && sda_i)
        else $error("write began outside stop");
    a_idle_wipers: assert property (idle_cnt > 16 |-> $stable(wiper_o))
        else $error("wiper moved on idle bus");
endmodule // pot_port_sva

bind quad_pot_wiper_command_port pot_port_sva #(.DEVICE_TYPE(DEVICE_TYPE), .NV_WRITE_CYCLES(NV_WRITE_CYCLES))
    u_pot_port_sva (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .dev_sel_i(dev_sel_i), .wiper_o(wiper_o), .busy_o(busy_o));

`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none

module tb_top
    import pot_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] TYPE_ID = 4'h3; // Arbitrary type nibble
    localparam logic [3:0] SEL = 4'h9;
    localparam int unsigned NV = 200;
    logic clk;
    logic resetn;
    logic scl;
    logic m_oe;
    logic d_sda;
    logic d_oe;
    logic [3:0] dev_sel;
    logic [CHANNELS-1:0][WIPER_W-1:0] wiper;
    logic busy;
    logic res;
    logic [7:0] res_data;
    logic look;
    wire sda;
    logic [7:0] bus_q[$];
    logic [31:0] wiper_q[$];
    logic [7:0] ew[4] = '{default: 8'h00};
    logic [7:0] es[16] = '{default: 8'h00};
    logic [31:0] seed = 32'h64963870;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
    // Open drain wire with pull-up
    assign sda = !m_oe && !(d_oe && !d_sda);
    quad_pot_wiper_command_port #(.DEVICE_TYPE(TYPE_ID), .NV_WRITE_CYCLES(NV)) u_quad_pot_wiper_command_port (
        .ref_clk_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda), .sda_o(d_sda), .sda_oe_o(d_oe),
        .dev_sel_i(dev_sel), .wiper_o(wiper), .busy_o(busy));
    bus_master_model u_bus_master_model (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe),
        .res_o(res), .res_data_o(res_data));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic compare_bus(input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch bus_result expected %h seen %h", e, s);
        end
    endtask
    task automatic compare_wiper(input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch wiper_o expected %h seen %h", e, s);
        end
    endtask
    // Oldest note against each result
    always @(posedge clk) begin
        if (res === 1'b1) compare_bus(bus_q.pop_front(), res_data);
        if (look === 1'b1) compare_wiper(wiper_q.pop_front(), wiper);
    end
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_fail++;
            $display("mismatch timeout expected done seen hung");
            complete_run();
        end
    end
    task automatic check_wipers();
        wiper_q.push_back({ew[3], ew[2], ew[1], ew[0]});
        look = 1'b1;
        @(negedge clk);
        look = 1'b0;
    endtask
    task automatic settle();
        repeat (12) @(negedge clk);
        while (busy !== 1'b0) @(negedge clk);
        repeat (8) @(negedge clk);
    endtask
    // Address and instruction, both acks as given
    task automatic head(input logic [7:0] ins, input logic ack);
        u_bus_master_model.start();
        bus_q.push_back({7'h00, ack});
        u_bus_master_model.send_byte({TYPE_ID, SEL});
        bus_q.push_back({7'h00, ack});
        u_bus_master_model.send_byte(ins);
    endtask
    task automatic cmd(input logic [7:0] ins, input bit dat, input logic [7:0] d);
        head(ins, 1'b1);
        if (dat) begin
            bus_q.push_back(8'h01);
            u_bus_master_model.send_byte(d);
        end
        u_bus_master_model.stop();
    endtask
    task automatic rd(input logic [7:0] ins, input logic [7:0] e);
        head(ins, 1'b1);
        bus_q.push_back(e);
        u_bus_master_model.read_byte();
        u_bus_master_model.stop();
        settle();
    endtask
    task automatic step(input logic [1:0] ch, input logic [2:0] p);
        head({OP_STEP, 2'h0, ch}, 1'b1);
        for (int i = 2; i >= 0; i--) u_bus_master_model.bit_out(p[i]);
        u_bus_master_model.stop();
        settle();
    endtask
    initial begin
        resetn = 1'b0;
        dev_sel = SEL;
        look = 1'b0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        settle();
        check_wipers();
        for (int c = 0; c < 4; c++) begin
            seed = lfsr(seed);
            ew[c] = seed[7:0];
            cmd({OP_WR_WIPER, 2'h0, c[1:0]}, 1'b1, ew[c]);
            settle();
            rd({OP_RD_WIPER, 2'h3, c[1:0]}, ew[c]);
        end
        check_wipers();
        seed = lfsr(seed);
        es[6] = seed[15:8];
        cmd({OP_WR_STORE, 2'h2, 2'h1}, 1'b1, es[6]);
        head({OP_RD_STORE, 2'h2, 2'h1}, 1'b0);
        u_bus_master_model.stop();
        settle();
        rd({OP_RD_STORE, 2'h2, 2'h1}, es[6]);
        ew[1] = es[6];
        cmd({OP_STORE_TO_WIPER, 2'h2, 2'h1}, 1'b0, 8'h00);
        settle();
        check_wipers();
        es[11] = ew[2];
        cmd({OP_WIPER_TO_STORE, 2'h3, 2'h2}, 1'b0, 8'h00);
        settle();
        rd({OP_RD_STORE, 2'h3, 2'h2}, es[11]);
        for (int c = 0; c < 4; c++) es[c * 4 + 1] = ew[c];
        cmd({OP_GLOBAL_TO_STORE, 2'h1, 2'h0}, 1'b0, 8'h00);
        settle();
        cmd({OP_WR_WIPER, 2'h0, 2'h0}, 1'b1, 8'hFE);
        settle();
        cmd({OP_WR_WIPER, 2'h0, 2'h3}, 1'b1, 8'h01);
        settle();
        step(2'h0, 3'b110);
        step(2'h3, 3'b001);
        ew[0] = 8'hFE;
        ew[3] = 8'h01;
        check_wipers();
        for (int c = 0; c < 4; c++) ew[c] = es[c * 4 + 1];
        cmd({OP_GLOBAL_TO_WIPER, 2'h1, 2'h0}, 1'b0, 8'h00);
        settle();
        check_wipers();
        dev_sel = ~SEL;
        head({OP_WR_WIPER, 2'h0, 2'h2}, 1'b0);
        bus_q.push_back(8'h00);
        u_bus_master_model.send_byte(8'h3C);
        u_bus_master_model.stop();
        dev_sel = SEL;
        // Unknown opcode refused, and the byte after it too
        u_bus_master_model.start();
        bus_q.push_back(8'h01);
        u_bus_master_model.send_byte({TYPE_ID, SEL});
        bus_q.push_back(8'h00);
        u_bus_master_model.send_byte(8'h30);
        bus_q.push_back(8'h00);
        u_bus_master_model.send_byte({OP_WR_WIPER, 2'h0, 2'h2});
        u_bus_master_model.stop();
        settle();
        check_wipers();
        seed = lfsr(seed);
        es[8] = seed[7:0];
        cmd({OP_WR_STORE, 2'h0, 2'h2}, 1'b1, es[8]);
        settle();
        resetn = 1'b0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        settle();
        for (int c = 0; c < 4; c++) ew[c] = es[c * 4];
        check_wipers();
        complete_run();
    end
endmodule // tb_top

`default_nettype wire
